//--- pkg/clk_ctrl_pkg.sv
// Constants, field layout and carrier types of the main clock controller
// Behaviour
// - Root clock drives an 8-bit prescaler producing the CPU domain clocks.
// - After reset the synchronous clocks run undivided.
// - CPU domain rate is root rate divided by the divider field.
// - Forbidden divider is stored, not applied, and flagged to the guard.
// - Divider field may be written at any time without halting anything.
// - New division reaches every clock of the domain at once.
// - Gating own or bridge clock locks the mask register until reset.
// - Settled flag rises when CPU clocks are ready; acts as wake source.
// - Writing one to enable-set enables, to enable-clear disables.
// - Interrupt stays high while flag and enable are both set.
// - Writing one to a flag bit clears it; zero leaves it.
// - In idle sleep the controller keeps running on the root clock.
// - In standby the clocks freeze when no consumer needs a clock.
// - Always enabled; no enable control and no software reset.
package clk_ctrl_pkg;
   localparam int DIV_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int MASK_W = 8;
   localparam int IRQ_W = 1;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN_CLR = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_EN_SET = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_CPU_DIV = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_CLK_MASK = 8'h10;
   // Field positions
   localparam int SETTLED_BIT = 0;
   localparam int MASK_SELF_BIT = 0;
   localparam int MASK_BRIDGE_BIT = 1;
   // Reset values
   localparam logic [DIV_W-1:0] CPU_DIV_RST = 8'h01;
   localparam logic [MASK_W-1:0] CLK_MASK_RST = 8'hff;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST = 1'h0;
   // Register request from the software port
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } regReq_type;
   // Sleep state from the power manager
   typedef struct packed {
      logic idle;
      logic standby;
      logic clkNeeded;
   } sleepCtl_type;
endpackage

//--- verif/sync_clock_divider_ctrl_tb.sv
// Self-checking bench for the main clock controller
`timescale 1ns/1ns
module sync_clock_divider_ctrl_tb
   import clk_ctrl_pkg::*;
();
   logic mclk = 1'b0;
   logic rst = 1'b1;
   regReq_type regReq = '0;
   sleepCtl_type sleep = '0;
   logic [DATA_W-1:0] rdata;
   logic cpuTick;
   logic frozen;
   logic guardViolation;
   logic irq;
   logic wakeReq;
   logic [DIV_W-1:0] cpuDivActive;
   logic [MASK_W-1:0] clkMask;
   int miscompares = 0;
   int samplesChecked = 0;
   int gap = 0;
   int tickCount = 0;
   int t0;
   logic armed = 1'b0;
   logic [DIV_W-1:0] lastDiv = '0;
   logic [DIV_W-1:0] d;
   logic [DIV_W-1:0] bad [4] = '{8'h00, 8'h03, 8'h06, 8'hff};

   // 50 MHz root clock
   always #10 mclk = ~mclk;

   sync_clock_divider_ctrl dut_u (
      .mclk(mclk),
      .rst(rst),
      .regReq(regReq),
      .rdata(rdata),
      .sleep(sleep),
      .cpuTick(cpuTick),
      .cpuDivActive(cpuDivActive),
      .frozen(frozen),
      .clkMask(clkMask),
      .guardViolation(guardViolation),
      .irq(irq),
      .wakeReq(wakeReq)
   );

   // Compare and count
   task automatic chk(input logic [DATA_W-1:0] got,
                      input logic [DATA_W-1:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One-cycle register write
   task automatic reg_wr(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] v);
      @(posedge mclk);
      regReq.addr <= a;
      regReq.wdata <= v;
      regReq.wr <= 1'b1;
      @(posedge mclk);
      regReq.wr <= 1'b0;
      #1;
   endtask

   // One-cycle read, data taken in the following cycle
   task automatic rd_chk(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] exp);
      @(posedge mclk);
      regReq.addr <= a;
      regReq.rd <= 1'b1;
      @(posedge mclk);
      regReq.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Bounded wait for a division switch
   task automatic wait_switch(input logic [DIV_W-1:0] v);
      int n;
      n = 0;
      while (cpuDivActive !== v && n < 600) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(cpuDivActive, v);
   endtask

   // Verdict, shared by main sequence and watchdog
   task automatic final_report;
      $display("Counts: %0d checked, %0d mismatched", samplesChecked,
         miscompares);
      if (miscompares == 0 && samplesChecked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Tick spacing must equal the division applied at the previous tick
   always @(negedge mclk) begin
      if (rst === 1'b1 || frozen === 1'b1) begin
         armed = 1'b0;
      end else if (cpuTick === 1'b1) begin
         if (armed) chk(gap, lastDiv);
         armed = 1'b1;
         gap = 1;
         lastDiv = cpuDivActive;
         tickCount++;
      end else begin
         gap++;
      end
   end

   // Watchdog
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      final_report;
   end

   // Test sequence
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      #1;
      // Reset values and unmapped address
      chk(cpuDivActive, 32'h1);
      rd_chk(OFF_CPU_DIV, 32'h1);
      rd_chk(OFF_IRQ_EN_SET, 32'h0);
      rd_chk(OFF_IRQ_FLAG, 32'h0);
      rd_chk(OFF_CLK_MASK, 32'hff);
      reg_wr(8'h14, 32'hffffffff);
      rd_chk(8'h14, 32'h0);
      $display("reset test done");
      // Every legal division, then back to undivided
      for (int i = 1; i <= 8; i++) begin
         d = (i == 8) ? 8'h01 : (8'h01 << i);
         reg_wr(OFF_CPU_DIV, {24'h0, d});
         chk(guardViolation, 1'b0);
         rd_chk(OFF_CPU_DIV, {24'h0, d});
         wait_switch(d);
         rd_chk(OFF_IRQ_FLAG, 32'h1);
         reg_wr(OFF_IRQ_FLAG, 32'h1);
         rd_chk(OFF_IRQ_FLAG, 32'h0);
         repeat (3 * int'(d)) @(posedge mclk);
      end
      $display("division test done");
      // Forbidden values are stored but not applied
      foreach (bad[i]) begin
         reg_wr(OFF_CPU_DIV, {24'h0, bad[i]});
         chk(guardViolation, 1'b1);
         rd_chk(OFF_CPU_DIV, {24'h0, bad[i]});
         repeat (4) @(posedge mclk);
         #1;
         chk(cpuDivActive, 32'h1);
      end
      $display("forbidden test done");
      // Interrupt enable, flag clear, disable
      reg_wr(OFF_IRQ_EN_SET, 32'h1);
      rd_chk(OFF_IRQ_EN_CLR, 32'h1);
      chk(irq, 1'b0);
      reg_wr(OFF_CPU_DIV, 32'h4);
      wait_switch(8'h04);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq, 1'b1);
      chk(wakeReq, 1'b1);
      reg_wr(OFF_IRQ_FLAG, 32'h0);
      @(posedge mclk);
      #1;
      chk(irq, 1'b1);
      reg_wr(OFF_IRQ_FLAG, 32'h1);
      @(posedge mclk);
      #1;
      chk(irq, 1'b0);
      reg_wr(OFF_CPU_DIV, 32'h2);
      wait_switch(8'h02);
      repeat (2) @(posedge mclk);
      #1;
      chk(irq, 1'b1);
      reg_wr(OFF_IRQ_EN_CLR, 32'h1);
      @(posedge mclk);
      #1;
      chk(irq, 1'b0);
      chk(wakeReq, 1'b0);
      rd_chk(OFF_IRQ_EN_SET, 32'h0);
      rd_chk(OFF_IRQ_FLAG, 32'h1);
      reg_wr(OFF_IRQ_FLAG, 32'h1);
      $display("interrupt test done");
      // Sleep: idle keeps running, standby freezes without consumers
      @(posedge mclk);
      sleep.idle <= 1'b1;
      t0 = tickCount;
      repeat (10) @(posedge mclk);
      chk(tickCount - t0, 32'd5);
      sleep.idle <= 1'b0;
      sleep.standby <= 1'b1;
      sleep.clkNeeded <= 1'b1;
      t0 = tickCount;
      repeat (10) @(posedge mclk);
      chk(tickCount - t0, 32'd5);
      sleep.clkNeeded <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(frozen, 1'b1);
      t0 = tickCount;
      repeat (10) @(posedge mclk);
      chk(tickCount - t0, 32'd0);
      sleep.clkNeeded <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk(frozen, 1'b0);
      @(posedge mclk);
      sleep.standby <= 1'b0;
      $display("sleep test done");
      // Mask lock until reset
      reg_wr(OFF_CLK_MASK, 32'haf);
      rd_chk(OFF_CLK_MASK, 32'haf);
      reg_wr(OFF_CLK_MASK, 32'hfd);
      chk(clkMask, 32'hfd);
      reg_wr(OFF_CLK_MASK, 32'hff);
      rd_chk(OFF_CLK_MASK, 32'hfd);
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rd_chk(OFF_CLK_MASK, 32'hff);
      rd_chk(OFF_CPU_DIV, 32'h1);
      reg_wr(OFF_CLK_MASK, 32'hfe);
      reg_wr(OFF_CLK_MASK, 32'hff);
      rd_chk(OFF_CLK_MASK, 32'hfe);
      $display("mask test done");
      final_report;
   end
endmodule

//--- verilog/irq_unit.sv
// Interrupt flags, enables and the request line
`timescale 1ns/1ns
module irq_unit
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Events and software strobes
   input wire logic [IRQ_W-1:0] setEv,
   input wire logic [IRQ_W-1:0] clrFlag,
   input wire logic [IRQ_W-1:0] enSet,
   input wire logic [IRQ_W-1:0] enClr,
   // State and request
   output logic [IRQ_W-1:0] flags,
   output logic [IRQ_W-1:0] enables,
   output logic irq
);
   genvar i;
   generate
      for (i = 0; i < IRQ_W; i++) begin : gSrc
         // Sticky flag, a new event beats the clear
         always_ff @(posedge mclk) begin
            if (rst) begin
               flags[i] <= 1'b0;
            end else if (setEv[i]) begin
               flags[i] <= 1'b1;
            end else if (clrFlag[i]) begin
               flags[i] <= 1'b0;
            end
         end
         // Enable bit set and cleared by one-writes
         always_ff @(posedge mclk) begin
            if (rst) begin
               enables[i] <= IRQ_EN_RST[i];
            end else if (enSet[i]) begin
               enables[i] <= 1'b1;
            end else if (enClr[i]) begin
               enables[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Level request while any enabled flag is set
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & enables);
      end
   end
endmodule

//--- verilog/sync_clock_divider_ctrl.sv
// Main clock controller: CPU divider, clock masks, sleep freeze, interrupt
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module sync_clock_divider_ctrl
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Register port
   input wire regReq_type regReq,
   output logic [DATA_W-1:0] rdata,
   // Sleep control
   input wire sleepCtl_type sleep,
   // CPU domain clocking
   output logic cpuTick,
   output logic [DIV_W-1:0] cpuDivActive,
   output logic frozen,
   // Clock masks
   output logic [MASK_W-1:0] clkMask,
   // Access guard, interrupt and wake
   output logic guardViolation,
   output logic irq,
   output logic wakeReq
);
   // Always enabled: no enable bit and no software reset exist here
   logic [DIV_W-1:0] cpuDivReg_ff;
   logic [DIV_W-1:0] reqDiv_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic [MASK_W-1:0] clkMask_ff;
   logic maskLocked_ff;
   logic guardViolation_ff;
   logic frozen_ff;
   logic wakeReq_ff;
   logic wrDiv;
   logic wrMask;
   logic wrFlag;
   logic wrEnSet;
   logic wrEnClr;
   logic divLegal;
   logic freezeNow;
   logic applied;
   logic [DIV_W-1:0] wDiv;
   logic [IRQ_W-1:0] flags;
   logic [IRQ_W-1:0] enables;
   logic [IRQ_W-1:0] setEv;
   logic [IRQ_W-1:0] clrFlag;
   logic [IRQ_W-1:0] enSet;
   logic [IRQ_W-1:0] enClr;

   // Address decode of the write strobe
   assign wrDiv = regReq.wr && regReq.addr == OFF_CPU_DIV;
   assign wrMask = regReq.wr && regReq.addr == OFF_CLK_MASK;
   assign wrFlag = regReq.wr && regReq.addr == OFF_IRQ_FLAG;
   assign wrEnSet = regReq.wr && regReq.addr == OFF_IRQ_EN_SET;
   assign wrEnClr = regReq.wr && regReq.addr == OFF_IRQ_EN_CLR;
   assign wDiv = regReq.wdata[DIV_W-1:0];

   // Legal divisions are powers of two from 1 to 128
   assign divLegal = (wDiv != '0) && ((wDiv & (wDiv - 8'h01)) == '0);

   // Freeze only in standby with no clock consumer
   assign freezeNow = sleep.standby && !sleep.clkNeeded;

   // Interrupt strobes: settled event from applied, software strobes from one-writes only
   assign setEv = IRQ_W'(applied);
   assign clrFlag = wrFlag ? regReq.wdata[IRQ_W-1:0] : '0;
   assign enSet = wrEnSet ? regReq.wdata[IRQ_W-1:0] : '0;
   assign enClr = wrEnClr ? regReq.wdata[IRQ_W-1:0] : '0;

   // Stored divider value, legal or not
   always_ff @(posedge mclk) begin
      if (rst) begin
         cpuDivReg_ff <= CPU_DIV_RST;
      end else if (wrDiv) begin
         cpuDivReg_ff <= wDiv;
      end
   end

   // Requested division, only legal values pass
   always_ff @(posedge mclk) begin
      if (rst) begin
         reqDiv_ff <= CPU_DIV_RST;
      end else if (wrDiv && divLegal) begin
         reqDiv_ff <= wDiv;
      end
   end

   // Violation pulse toward the access guard
   always_ff @(posedge mclk) begin
      if (rst) begin
         guardViolation_ff <= 1'b0;
      end else begin
         guardViolation_ff <= wrDiv && !divLegal;
      end
   end

   // Clock mask register with lock after gating own or bridge clock
   always_ff @(posedge mclk) begin
      if (rst) begin
         clkMask_ff <= CLK_MASK_RST;
      end else if (wrMask && !maskLocked_ff) begin
         clkMask_ff <= regReq.wdata[MASK_W-1:0];
      end
   end

   // Lock holds until system reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         maskLocked_ff <= 1'b0;
      end else if (!clkMask_ff[MASK_SELF_BIT] ||
                   !clkMask_ff[MASK_BRIDGE_BIT]) begin
         maskLocked_ff <= 1'b1;
      end
   end

   // Sleep state, idle leaves the clocks running
   always_ff @(posedge mclk) begin
      if (rst) begin
         frozen_ff <= 1'b0;
      end else begin
         frozen_ff <= freezeNow;
      end
   end

   // Wake request while settled flag is pending and enabled
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeReq_ff <= 1'b0;
      end else begin
         wakeReq_ff <= flags[SETTLED_BIT] && enables[SETTLED_BIT];
      end
   end

   // Read mux, data valid only in the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= '0;
         if (regReq.rd) begin
            unique case (regReq.addr)
               OFF_IRQ_EN_CLR: rdata_ff <= DATA_W'(enables);
               OFF_IRQ_EN_SET: rdata_ff <= DATA_W'(enables);
               OFF_IRQ_FLAG: rdata_ff <= DATA_W'(flags);
               OFF_CPU_DIV: rdata_ff <= DATA_W'(cpuDivReg_ff);
               OFF_CLK_MASK: rdata_ff <= DATA_W'(clkMask_ff);
               default: rdata_ff <= '0;
            endcase
         end
      end
   end

   // Prescaler shared by every clock of the CPU domain
   sync_prescaler uPrescaler (
      .mclk(mclk),
      .rst(rst),
      .reqDiv(reqDiv_ff),
      .freeze(freezeNow),
      .tick(cpuTick),
      .activeDiv(cpuDivActive),
      .applied(applied)
   );

   // Flag, enable and request logic
   irq_unit uIrq (
      .mclk(mclk),
      .rst(rst),
      .setEv(setEv),
      .clrFlag(clrFlag),
      .enSet(enSet),
      .enClr(enClr),
      .flags(flags),
      .enables(enables),
      .irq(irq)
   );

   // Output drive from flip-flops
   assign rdata = rdata_ff;
   assign clkMask = clkMask_ff;
   assign guardViolation = guardViolation_ff;
   assign frozen = frozen_ff;
   assign wakeReq = wakeReq_ff;

   // Helper: cycles between ticks and the division owning each gap
   logic [DIV_W:0] gap_ff;
   logic [DIV_W-1:0] gapDiv_ff;
   logic gapValid_ff;
   always_ff @(posedge mclk) begin
      if (rst) begin
         gap_ff <= '0;
         gapDiv_ff <= CPU_DIV_RST;
         gapValid_ff <= 1'b0;
      end else if (freezeNow) begin
         gapValid_ff <= 1'b0;
      end else if (cpuTick) begin
         gap_ff <= 9'h001;
         gapDiv_ff <= cpuDivActive;
         gapValid_ff <= 1'b1;
      end else begin
         gap_ff <= gap_ff + 9'h001;
      end
   end

   // Forbidden write: stored and flagged, request unchanged
   sequence s_badWrite;
      wrDiv && !divLegal;
   endsequence
   sequence s_keptAndFlagged;
      guardViolation && $stable(reqDiv_ff) && cpuDivReg_ff == $past(wDiv);
   endsequence
   property p_forbidden_kept;
      @(posedge mclk) disable iff (rst) s_badWrite |=> s_keptAndFlagged;
   endproperty
   a_forbidden_kept:
      assert property (p_forbidden_kept)
      else $error("forbidden divider not handled");

   // Legal write taken at once, whatever else runs
   property p_legal_taken;
      @(posedge mclk) disable iff (rst)
         wrDiv && divLegal |=> reqDiv_ff == $past(wDiv) && !guardViolation;
   endproperty
   a_legal_taken:
      assert property (p_legal_taken)
      else $error("legal divider write not taken");

   // Reset leaves the domain undivided
   property p_reset_undivided;
      @(posedge mclk) rst |=> cpuDivActive == CPU_DIV_RST &&
         cpuDivReg_ff == CPU_DIV_RST;
   endproperty
   a_reset_undivided:
      assert property (p_reset_undivided)
      else $error("divider not undivided after reset");

   // Tick spacing equals the division owning the gap
   property p_tick_spacing;
      @(posedge mclk) disable iff (rst)
         cpuTick && gapValid_ff && !freezeNow |->
            gap_ff == {1'b0, gapDiv_ff};
   endproperty
   a_tick_spacing:
      assert property (p_tick_spacing)
      else $error("tick spacing differs from division");

   // Division changes only together with a tick
   property p_switch_at_boundary;
      @(posedge mclk) disable iff (rst)
         $changed(cpuDivActive) |-> cpuTick;
   endproperty
   a_switch_at_boundary:
      assert property (p_switch_at_boundary)
      else $error("division switched mid period");

   // Settled flag follows an applied switch
   sequence s_switched;
      $changed(cpuDivActive);
   endsequence
   property p_settled_after_switch;
      @(posedge mclk) disable iff (rst)
         s_switched |=> flags[SETTLED_BIT];
   endproperty
   a_settled_after_switch:
      assert property (p_settled_after_switch)
      else $error("settled flag missing after switch");

   // Locked mask ignores writes
   property p_mask_locked;
      @(posedge mclk) disable iff (rst)
         maskLocked_ff && wrMask |=> $stable(clkMask);
   endproperty
   a_mask_locked:
      assert property (p_mask_locked)
      else $error("locked mask register changed");

   // Gating own clock locks the mask in the next cycle
   property p_mask_lock_set;
      @(posedge mclk) disable iff (rst)
         !clkMask[MASK_SELF_BIT] |=> maskLocked_ff;
   endproperty
   a_mask_lock_set:
      assert property (p_mask_lock_set)
      else $error("mask lock not set");

   // Wake follows an enabled settled flag
   property p_wake;
      @(posedge mclk) disable iff (rst)
         flags[SETTLED_BIT] && enables[SETTLED_BIT] |=> wakeReq;
   endproperty
   a_wake:
      assert property (p_wake)
      else $error("wake not raised");

   // Enable-clear drops the request two cycles later
   property p_enable_clear;
      @(posedge mclk) disable iff (rst)
         wrEnClr && regReq.wdata[SETTLED_BIT] && !wrEnSet |=> ##1 !irq;
   endproperty
   a_enable_clear:
      assert property (p_enable_clear)
      else $error("request stayed after enable clear");

   // Request follows enabled pending flag and holds with it
   sequence s_pending;
      flags[SETTLED_BIT] && enables[SETTLED_BIT];
   endsequence
   property p_irq_level;
      @(posedge mclk) disable iff (rst) s_pending [*2] |-> irq;
   endproperty
   a_irq_level:
      assert property (p_irq_level)
      else $error("request not asserted");

   // One-write clears the flag unless a new event lands
   property p_flag_clear;
      @(posedge mclk) disable iff (rst)
         wrFlag && regReq.wdata[SETTLED_BIT] && !applied |=>
            !flags[SETTLED_BIT];
   endproperty
   a_flag_clear:
      assert property (p_flag_clear)
      else $error("flag not cleared");

   // Zero-write leaves the flag alone
   property p_flag_keep;
      @(posedge mclk) disable iff (rst)
         wrFlag && !regReq.wdata[SETTLED_BIT] && flags[SETTLED_BIT] |=>
            flags[SETTLED_BIT];
   endproperty
   a_flag_keep:
      assert property (p_flag_keep)
      else $error("flag lost on zero write");

   // Idle sleep keeps the clocks running
   property p_idle_runs;
      @(posedge mclk) disable iff (rst)
         sleep.idle && !sleep.standby |=> !frozen;
   endproperty
   a_idle_runs:
      assert property (p_idle_runs)
      else $error("clocks frozen in idle");

   // Standby with no consumer stops the tick
   property p_standby_freeze;
      @(posedge mclk) disable iff (rst)
         freezeNow |=> !cpuTick && frozen;
   endproperty
   a_standby_freeze:
      assert property (p_standby_freeze)
      else $error("tick during standby freeze");

   // Read back of the stored divider
   property p_div_readback;
      @(posedge mclk) disable iff (rst)
         regReq.rd && regReq.addr == OFF_CPU_DIV |=>
            rdata == DATA_W'($past(cpuDivReg_ff));
   endproperty
   a_div_readback:
      assert property (p_div_readback)
      else $error("divider read back wrong");
endmodule

//--- verilog/sync_prescaler.sv
// Prescaler that produces the CPU domain clock tick
`timescale 1ns/1ns
module sync_prescaler
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Control
   input wire logic [DIV_W-1:0] reqDiv,
   input wire logic freeze,
   // Outputs
   output logic tick,
   output logic [DIV_W-1:0] activeDiv,
   output logic applied
);
   logic [DIV_W-1:0] cnt_ff;
   logic boundary;

   // End of the current divided period
   assign boundary = (cnt_ff == activeDiv - 8'h01);

   // Period counter, held while frozen
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (!freeze) begin
         cnt_ff <= boundary ? '0 : cnt_ff + 8'h01;
      end
   end

   // Domain tick, one per divided period
   always_ff @(posedge mclk) begin
      if (rst) begin
         tick <= 1'b0;
      end else begin
         tick <= boundary && !freeze;
      end
   end

   // Division switch only at a period boundary
   always_ff @(posedge mclk) begin
      if (rst) begin
         activeDiv <= CPU_DIV_RST;
         applied <= 1'b0;
      end else begin
         applied <= 1'b0;
         if (boundary && !freeze && reqDiv != activeDiv) begin
            activeDiv <= reqDiv;
            applied <= 1'b1;
         end
      end
   end
endmodule
